// ==== fbp_pkg.sv ====
/*
  Shared constants for the flash block protection logic: array geometry,
  protection codes and the command state machine encoding.
  Assumes a 32-bit word-organised flash array behind the block.
*/
`default_nettype none
package fbp_pkg;
  // Array geometry in bytes
  localparam int FBP_ARRAY_BYTES = 131072;
  localparam int FBP_BLOCK_BYTES = 1024;
  localparam int FBP_REGION_BYTES = 2048;
  localparam int FBP_WORD_BYTES = 4;
  localparam int FBP_WORDS = FBP_ARRAY_BYTES / FBP_WORD_BYTES;
  localparam int FBP_BLOCK_WORDS = FBP_BLOCK_BYTES / FBP_WORD_BYTES;
  localparam int FBP_BLOCKS = FBP_ARRAY_BYTES / FBP_BLOCK_BYTES;
  localparam int FBP_REGIONS = FBP_ARRAY_BYTES / FBP_REGION_BYTES;
  localparam int FBP_WADDR_W = $clog2(FBP_WORDS);
  localparam int FBP_BADDR_W = $clog2(FBP_BLOCKS);
  localparam int FBP_BOFF_W = $clog2(FBP_BLOCK_WORDS);
  localparam int FBP_RADDR_W = $clog2(FBP_REGIONS);

  // Erased state of a word
  localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [31:0] FBP_ZERO_WORD = 32'h0000_0000;

  // Protection modes, two bits per region
  typedef enum logic [1:0] {
    FBP_PROT_OPEN = 2'h0,
    FBP_PROT_RDONLY = 2'h1,
    FBP_PROT_XONLY = 2'h2
  } fbp_prot_t;

  // Command engine states
  typedef enum logic [2:0] {
    FBP_ST_IDLE = 3'b001,
    FBP_ST_ERASE = 3'b010,
    FBP_ST_DONE = 3'b100
  } fbp_state_t;
endpackage
`default_nettype wire

// ==== fbp_region_check.sv ====
/*
  Protection check for one access: looks up the region of a word address
  and tells whether writes and data reads are allowed there.
  Assumes the protection map is a flat vector of two bits per region.
*/
`timescale 1ns/10ps
`default_nettype none
module fbp_region_check
  import fbp_pkg::*;
(
  // Lookup
  input wire logic [FBP_WADDR_W-1:0] addr_i,
  input wire logic [2*FBP_REGIONS-1:0] prot_map_i,
  // Verdict
  output logic write_ok_o,
  output logic data_read_ok_o
);
  logic [FBP_RADDR_W-1:0] region;
  logic [1:0] mode;

  // Region is the top address bits; two erase blocks share one region
  assign region = addr_i[FBP_WADDR_W-1 -: FBP_RADDR_W];
  assign mode = prot_map_i[2*region +: 2];
  // Any protection blocks erase and program
  assign write_ok_o = (mode == FBP_PROT_OPEN);
  // Only execute-only hides data from data reads and debugger
  assign data_read_ok_o = (mode != FBP_PROT_XONLY);
endmodule
`default_nettype wire

// ==== fbp_top.sv ====
/*
  Flash block protection: 128 KB array of 1 KB erase blocks with per-2 KB
  region protection, serving fetch, data read, program and erase requests.
  Assumes requesters hold a request until ack; the protection map is a
  plain input held stable by the system.
  Array contents are not reset: a block is erased before it is read.
  Kinds are fetch, data read, program and erase; only a fetch may see
  execute-only contents, and mode code 3 acts as write-protected.
*/
// How it works
// - Array is 128 KB in 1 KB blocks, each erased alone.
// - Erase writes all ones over every word of one block.
// - Two adjacent blocks form one 2 KB region with one protection mode.
// - Read-only regions refuse erase and program, data reads still allowed.
// - Execute-only regions refuse writes, return contents to fetches only.
// - Data or debugger reads of execute-only regions never return contents.
`timescale 1ns/10ps
`default_nettype none
module fbp_top
  import fbp_pkg::*;
#(
  parameter int WORDS = FBP_WORDS
)(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Protection map, two bits per region
  input wire logic [2*FBP_REGIONS-1:0] PROT_MAP_I,
  // Request
  input wire logic REQ_I,
  input wire logic [1:0] REQ_KIND_I,
  input wire logic [FBP_WADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  // Answer
  output logic ACK_O,
  output logic DENIED_O,
  output logic [31:0] RDATA_O,
  output logic BUSY_O,
  // Violation status
  input wire logic VIOL_CLR_I,
  output logic VIOL_O
);
  // Request kinds
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_PROG = 2'h2;
  localparam logic [1:0] KIND_ERASE = 2'h3;
  // Erase walk limits and step
  localparam logic [FBP_BOFF_W-1:0] BOFF_ZERO = '0;
  localparam logic [FBP_BOFF_W-1:0] BOFF_LAST = '1;
  localparam logic [FBP_BOFF_W-1:0] BOFF_ONE = {{(FBP_BOFF_W-1){1'b0}}, 1'b1};
  localparam logic [FBP_BADDR_W-1:0] BLK_ZERO = '0;

  // Flash array; contents survive reset
  logic [31:0] mem [0:WORDS-1];

  // Command engine
  fbp_state_t state_reg;
  logic [FBP_BADDR_W-1:0] blk_reg;
  logic [FBP_BOFF_W-1:0] boff_reg;
  logic [FBP_BOFF_W-1:0] boff_next;
  logic erase_last;

  // Answer and status registers
  logic ack_reg;
  logic ack_next;
  logic denied_reg;
  logic [31:0] rdata_reg;
  logic viol_reg;

  // Protection verdict and request decode
  logic write_ok;
  logic data_read_ok;
  logic idle_req;
  logic allowed;
  logic is_read;
  logic serve_read;
  logic do_prog;
  logic start_erase;
  logic violation;

  fbp_region_check u_check (
    .addr_i(ADDR_I),
    .prot_map_i(PROT_MAP_I),
    .write_ok_o(write_ok),
    .data_read_ok_o(data_read_ok)
  );

  // Verdict for the request taken in idle; fetches always pass
  // Never taken in its own ack cycle, so a late drop is not served twice
  assign idle_req = REQ_I && (state_reg == FBP_ST_IDLE) && !ack_reg;
  always_comb begin
    case (REQ_KIND_I)
      KIND_FETCH: allowed = 1'b1;
      KIND_READ: allowed = data_read_ok;
      default: allowed = write_ok;
    endcase
  end
  assign do_prog = idle_req && allowed && (REQ_KIND_I == KIND_PROG);
  assign start_erase = idle_req && allowed && (REQ_KIND_I == KIND_ERASE);
  assign violation = idle_req && !allowed;
  // Kinds that return array contents when allowed
  assign is_read = (REQ_KIND_I == KIND_FETCH) || (REQ_KIND_I == KIND_READ);

  // Command state; erase walks one word per cycle, simple but keeps one write port
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= FBP_ST_IDLE;
    end else begin
      case (state_reg)
        // Idle: only an allowed erase leaves; other kinds answer at once
        FBP_ST_IDLE: begin
          if (start_erase) begin
            state_reg <= FBP_ST_ERASE;
          end
        end
        // Erase: one word per cycle until the last offset
        FBP_ST_ERASE: begin
          if (erase_last) begin
            state_reg <= FBP_ST_DONE;
          end
        end
        // Done: one cycle to raise the ack
        FBP_ST_DONE: begin
          state_reg <= FBP_ST_IDLE;
        end
        // Stray code back to idle
        default: begin
          state_reg <= FBP_ST_IDLE;
        end
      endcase
    end
  end

  // Walk bookkeeping; the offset wraps to zero as the walk ends
  assign erase_last = (state_reg == FBP_ST_ERASE) && (boff_reg == BOFF_LAST);
  assign boff_next = boff_reg + BOFF_ONE;

  // Block under erase, latched when the erase is taken
  // Held through the walk so a changing address cannot move it
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      blk_reg <= BLK_ZERO;
    end else if (start_erase) begin
      blk_reg <= ADDR_I[FBP_WADDR_W-1 -: FBP_BADDR_W];
    end
  end

  // Word offset inside the block under erase
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      boff_reg <= BOFF_ZERO;
    end else if (start_erase) begin
      boff_reg <= BOFF_ZERO;
    end else if (state_reg == FBP_ST_ERASE) begin
      boff_reg <= boff_next;
    end
  end

  // Array writes; no reset so it maps to a memory
  // Erase has priority; no request is taken while it runs
  always_ff @(posedge CLK_I) begin
    if (state_reg == FBP_ST_ERASE) begin
      mem[{blk_reg, boff_reg}] <= FBP_ERASED_WORD;
    end else if (do_prog) begin
      // Program only clears bits, as flash cells do
      mem[ADDR_I] <= mem[ADDR_I] & WDATA_I;
    end
  end

  // Ack pulse one cycle after a take, or after the erase done cycle
  // Registered so the requester sees a clean one-cycle pulse
  assign ack_next = (state_reg == FBP_ST_DONE) || (idle_req && !start_erase);
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  // Refusal status, held until the next answer
  // Granted requests and erase completion clear it
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      denied_reg <= 1'b0;
    end else if (ack_next) begin
      denied_reg <= violation;
    end
  end

  // Read data only for allowed fetches and reads; zero for every other answer
  // so a refused, program or erase answer never carries array contents
  assign serve_read = idle_req && allowed && is_read;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_reg <= FBP_ZERO_WORD;
    end else if (serve_read) begin
      rdata_reg <= mem[ADDR_I];
    end else if (ack_next) begin
      rdata_reg <= FBP_ZERO_WORD;
    end
  end

  // Sticky violation flag; a new violation beats a clear
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      viol_reg <= 1'b0;
    end else if (violation) begin
      viol_reg <= 1'b1;
    end else if (VIOL_CLR_I) begin
      viol_reg <= 1'b0;
    end
  end

  // Outputs straight from registers; busy decodes the state
  assign ACK_O = ack_reg;
  assign DENIED_O = denied_reg;
  assign RDATA_O = rdata_reg;
  assign BUSY_O = (state_reg != FBP_ST_IDLE);
  assign VIOL_O = viol_reg;
endmodule
`default_nettype wire

// ==== fbp_props.sv ====
/* Port checker for fbp_top, attached by the bind at the foot.
   Assumes one clock domain and a stable protection map. */
`timescale 1ns/10ps
`default_nettype none
module fbp_props(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Request side
  input wire logic REQ_I,
  input wire logic [1:0] REQ_KIND_I,
  input wire logic [14:0] ADDR_I,
  input wire logic [127:0] PROT_MAP_I,
  input wire logic VIOL_CLR_I,
  // Answer side
  input wire logic ACK_O,
  input wire logic DENIED_O,
  input wire logic BUSY_O,
  input wire logic VIOL_O,
  input wire logic [31:0] RDATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Mode of the addressed 2 KB region, and a taken request
  wire [1:0] m = PROT_MAP_I[{ADDR_I[14:9], 1'b0} +: 2];
  wire t = REQ_I && !ACK_O && !BUSY_O;
  sequence s_busy; BUSY_O [*8] ##249 BUSY_O; endsequence
  sequence s_end; ACK_O && !BUSY_O && !DENIED_O; endsequence
  property p_erase; t && REQ_KIND_I == 2'h3 && m == 2'h0 |=> s_busy ##1 s_end; endproperty
  a_erase: assert property (p_erase) else $error("erase timing");
  property p_wr; t && REQ_KIND_I[1] && m != 2'h0 |=> ACK_O && DENIED_O; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  property p_pgm; t && REQ_KIND_I == 2'h2 && m == 2'h0 |=> ACK_O && !DENIED_O; endproperty
  a_pgm: assert property (p_pgm) else $error("program refused");
  property p_rd; t && REQ_KIND_I == 2'h1 && m != 2'h2 |=> ACK_O && !DENIED_O; endproperty
  a_rd: assert property (p_rd) else $error("read refused");
  property p_fetch; t && REQ_KIND_I == 2'h0 |=> ACK_O && !DENIED_O; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch refused");
  property p_xo; t && REQ_KIND_I == 2'h1 && m == 2'h2 |=> ACK_O && DENIED_O && RDATA_O == 0; endproperty
  a_xo: assert property (p_xo) else $error("xonly read served");
  property p_viol; ACK_O && DENIED_O |-> VIOL_O && RDATA_O == 0; endproperty
  a_viol: assert property (p_viol) else $error("no violation");
  property p_stick; $fell(VIOL_O) |-> $past(VIOL_CLR_I); endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
endmodule
bind fbp_top fbp_props i_fbp_props(.CLK_I, .RESET_I, .REQ_I, .ACK_O, .DENIED_O, .BUSY_O, .VIOL_O,
  .VIOL_CLR_I, .REQ_KIND_I, .ADDR_I, .PROT_MAP_I, .RDATA_O);
`default_nettype wire

// ==== fbp_master.sv ====
/* Requester model: one request at a time.
   Assumes ACK_O is a one-cycle pulse. */
`timescale 1ns/10ps
`default_nettype none
module fbp_master(
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  // Request
  output logic req_o = 0,
  output logic [1:0] kind_o = 0,
  output logic [14:0] addr_o = 0,
  output logic [31:0] wdata_o = 0
);
  // Hold until ack seen, then drop the request and invert address and data; kind is kept
  task automatic xfer(input logic [1:0] k, input logic [14:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output int ok);
    int n;
    n = 0;
    @(negedge clk_i);
    req_o = 1;
    kind_o = k;
    addr_o = a;
    wdata_o = d;
    do begin @(negedge clk_i); n++; end while (ack_i !== 1'b1 && n < 400);
    rd = rdata_i;
    ok = ack_i === 1'b1;
    @(negedge clk_i);
    req_o = 0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ==== fbp_top_tb_top.sv ====
/* Random bench for fbp_top over open, read-only and execute-only regions.
   Assumes fbp_props is bound and fbp_master drives requests. */
`timescale 1ns/10ps
`default_nettype none
module fbp_top_tb_top;
  logic CLK_I = 0, RESET_I = 1, VIOL_CLR_I = 0, REQ_I, ACK_O, DENIED_O, BUSY_O, VIOL_O;
  logic [127:0] PROT_MAP_I = 0;
  logic [1:0] REQ_KIND_I, k;
  logic [14:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rd, mem [1536];
  int fail_count = 0, n_compared = 0, ok;
  always #10 CLK_I = ~CLK_I;
  fbp_top i_fbp_top(.CLK_I, .RESET_I, .PROT_MAP_I, .REQ_I, .REQ_KIND_I, .ADDR_I, .WDATA_I,
    .ACK_O, .DENIED_O, .RDATA_O, .BUSY_O, .VIOL_CLR_I, .VIOL_O);
  fbp_master i_fbp_master(.clk_i(CLK_I), .ack_i(ACK_O), .rdata_i(RDATA_O), .req_o(REQ_I),
    .kind_o(REQ_KIND_I), .addr_o(ADDR_I), .wdata_o(WDATA_I));
  function automatic logic exp_den(logic [1:0] q, logic [1:0] m);
    return q[1] ? m != 0 : q == 1 && m == 2;
  endfunction
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin fail_count++; $display("mismatch %0t %h %h", $time, s, e); end
  endtask
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One request against the array model; flag cleared after
  task automatic op(logic [1:0] q, logic [14:0] a, logic [31:0] d);
    logic den;
    den = exp_den(q, PROT_MAP_I[2*a[14:9] +: 2]);
    i_fbp_master.xfer(q, a, d, rd, ok);
    chk(ok, 1);
    chk(DENIED_O, den);
    chk(VIOL_O, den);
    chk(rd, (!den && !q[1]) ? mem[a] : 0);
    if (!den && q == 2) mem[a] &= d;
    if (!den && q == 3) for (int i = 0; i < 256; i++) mem[{a[14:8], 8'h00} + i] = '1;
    VIOL_CLR_I = 1;
    @(negedge CLK_I);
    VIOL_CLR_I = 0;
  endtask
  initial begin #1000000; fail_count++; finish_test(); end
  initial begin
    void'($urandom(32'h3f27));
    repeat (8) @(negedge CLK_I);
    RESET_I = 0;
    for (int b = 0; b < 6; b++) op(2'h3, 15'(b * 256), 0);
    for (int r = 3; r < 64; r++) PROT_MAP_I[2*r +: 2] = 2'($urandom_range(2));
    PROT_MAP_I[5:0] = 6'h24;
    op(2'h2, 15'h0005, 32'h0f0f_0f0f);
    op(2'h1, 15'h0005, 0);
    op(2'h3, 15'h0300, 0);
    // Clear held across a refused take: the new violation must win
    fork
      op(2'h1, 15'h0400, 0);
      begin
        @(negedge CLK_I);
        VIOL_CLR_I = 1;
        @(negedge CLK_I);
        VIOL_CLR_I = 0;
      end
    join
    // Erase kept rare, it is long; map of the used regions reshuffled, all four codes
    for (int i = 0; i < 120; i++) begin
      if (i % 16 == 8) PROT_MAP_I[5:0] = 6'($urandom);
      k = 2'($urandom_range(3));
      if (k == 3 && i % 4 != 0) k = 2'h1;
      op(k, 15'($urandom_range(1535)), $urandom);
    end
    // Reset in mid-run after a refusal clears answer and flag, array kept
    PROT_MAP_I[5:0] = 6'h24;
    i_fbp_master.xfer(2'h1, 15'h0400, 0, rd, ok);
    chk(VIOL_O, 1);
    chk(DENIED_O, 1);
    RESET_I = 1;
    @(negedge CLK_I);
    chk(VIOL_O, 0);
    chk(DENIED_O, 0);
    RESET_I = 0;
    op(2'h0, 15'h0005, 0);
    finish_test();
  end
endmodule
`default_nettype wire
